//--- core/watch_timer_consts.vh
// Register indices, field positions, reset values and timing counts of the watch timer
`ifndef WATCH_TIMER_CONSTS_VH
`define WATCH_TIMER_CONSTS_VH

// Register indices; the APB byte address is four times the index
`define WMC_IDX            16'hff4a
`define IRQ_STATUS_IDX     16'hff4b
`define IRQ_MASK_IDX       16'hff4c
`define COUNT_STATE_IDX    16'hff4d

// Field positions of watch_mode_control
`define CCS_BIT            7
`define ISEL_HI            6
`define ISEL_LO            4
`define CRUN_BIT           1
`define OPEN_BIT           0

// Reset values
`define WMC_RESET          8'h00
`define IRQ_MASK_RESET     2'h0

// Writable bits of watch_mode_control; bits 2 and 3 read as zero
`define WMC_WRITE_MASK     8'hf3

// Interrupt status layout
`define EVT_WATCH_BIT      0
`define EVT_INTERVAL_BIT   1
`define EVT_WIDTH          2

// Counter widths and taps
`define PRESCALER_WIDTH    9
`define WATCH_CNT_WIDTH    5
`define ISEL_MAX           3'h5
`define TAP_BASE           4

// Main clock to watch clock divider, 2^7
`define MAIN_DIV_WIDTH     7
`define MAIN_DIV_LAST      7'h7f

`endif

//--- core/watch_clock_select.v
// Watch count clock selector: main clock divided by 128 or subsystem clock edges
`timescale 1ns/10ps
`include "watch_timer_consts.vh"

module watch_clock_select (
  input  wire pclk,
  input  wire presetn,
  input  wire sub_select,
  input  wire sub_clock,
  output reg  tick_q
);

  reg [`MAIN_DIV_WIDTH-1:0] div_q;
  reg                       sub_prev_q;

  // Free running divider so a source switch never waits a full wrap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // Subsystem clock is taken as synchronous to pclk, so no synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= sub_clock;
    end
  end

  // One pclk pulse per watch clock period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else if (sub_select) begin
      tick_q <= sub_clock & ~sub_prev_q;
    end else begin
      tick_q <= (div_q == `MAIN_DIV_LAST);
    end
  end

endmodule // watch_clock_select

//--- core/watch_interval_timer.v
// Watch timer with interval timer, APB register slave and shared interrupt
//
// Overview of operation
// - Clock select bit: 0 picks main clock over 128, 1 picks subsystem clock.
// - Interval code 0 to 5 picks prescaler tap 2^4 to 2^9; others prohibited.
// - A 9-bit prescaler on the watch clock feeds a 5-bit counter.
// - Counter-run 0 stops and clears the 5-bit counter; 1 starts it.
// - Operation-enable 0 stops everything, holding prescaler and counter cleared.
// - Watch counting runs only with operation-enable and counter-run both set.
// - Watch interrupt comes every half second from a 32.768 kHz watch clock.
// - Interval interrupt repeats each selected tap period while enabled.
// - Watch and interval share one prescaler and one interrupt request.
// - Clearing only counter-run restarts the watch count, prescaler untouched.
// - First watch overflow after counter restart may be off one prescaler period.
// - After enable the counter starts one prescaler cycle late.
// - Reset clears the mode register, stopping the block, main clock selected.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "watch_timer_consts.vh"

module watch_interval_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sub_clock,
  output reg         watch_interrupt_request
);

  // Watch counter sequencing states
  localparam [1:0] ST_STOPPED  = 2'b00;
  localparam [1:0] ST_ARMING   = 2'b01;
  localparam [1:0] ST_COUNTING = 2'b10;

  reg  [7:0]                    watch_mode_control_q;
  reg  [`EVT_WIDTH-1:0]         irq_status_q;
  reg  [`EVT_WIDTH-1:0]         irq_status_d;
  reg  [`EVT_WIDTH-1:0]         irq_mask_q;
  reg  [`PRESCALER_WIDTH-1:0]   prescaler_q;
  reg  [`WATCH_CNT_WIDTH-1:0]   watch_cnt_q;
  reg  [1:0]                    state_q;
  reg  [1:0]                    state_d;
  reg                           watch_evt;
  reg                           interval_evt;
  reg                           tap_hit;
  reg  [31:0]                   rdata_d;
  reg                           rerr_d;
  wire                          watch_count_clock;
  wire                          count_clock_select;
  wire [2:0]                    interval_select;
  wire                          counter_run;
  wire                          operation_enable;
  wire                          prescaler_wrap;
  wire                          setup_access;
  wire                          write_now;
  wire [15:0]                   reg_idx;
  wire                          hit_wmc;
  wire                          hit_status;
  wire                          hit_mask;
  wire                          hit_state;
  wire                          hit_any;
  wire [`PRESCALER_WIDTH-1:0]   tap_mask [0:5];

  // Mode register fields
  assign count_clock_select = watch_mode_control_q[`CCS_BIT];
  assign interval_select    = watch_mode_control_q[`ISEL_HI:`ISEL_LO];
  assign counter_run        = watch_mode_control_q[`CRUN_BIT];
  assign operation_enable   = watch_mode_control_q[`OPEN_BIT];

  // APB decode; the register index sits above the two byte address bits
  assign reg_idx    = paddr[17:2];
  assign hit_wmc    = (reg_idx == `WMC_IDX);
  assign hit_status = (reg_idx == `IRQ_STATUS_IDX);
  assign hit_mask   = (reg_idx == `IRQ_MASK_IDX);
  assign hit_state  = (reg_idx == `COUNT_STATE_IDX);
  assign hit_any    = hit_wmc | hit_status | hit_mask | hit_state;

  // One wait state: pready rises in the second access cycle
  assign setup_access = psel & penable & ~pready;
  assign write_now    = psel & penable & pready & pwrite;

  // Watch count clock source
  watch_clock_select u_clock_select (
    .pclk       (pclk),
    .presetn    (presetn),
    .sub_select (count_clock_select),
    .sub_clock  (sub_clock),
    .tick_q     (watch_count_clock)
  );

  // Per-tap masks of the low prescaler bits, one per interval code
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_tap
      assign tap_mask[g] = {`PRESCALER_WIDTH{1'b1}} >> (`PRESCALER_WIDTH - `TAP_BASE - g);
    end
  endgenerate

  // Full prescaler cycle ends on this watch clock tick
  assign prescaler_wrap = watch_count_clock & (&prescaler_q);

  // Mode register; bits 2 and 3 are held zero whatever software writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_mode_control_q <= `WMC_RESET;
    end else if (write_now && hit_wmc) begin
      watch_mode_control_q <= pwdata[7:0] & `WMC_WRITE_MASK;
    end
  end

  // Interrupt mask, 1 lets a status bit reach the request line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `IRQ_MASK_RESET;
    end else if (write_now && hit_mask) begin
      irq_mask_q <= pwdata[`EVT_WIDTH-1:0];
    end
  end

  // Prescaler keeps running while enabled; only operation_enable clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_q <= 9'h000;
    end else if (!operation_enable) begin
      prescaler_q <= 9'h000;
    end else if (watch_count_clock) begin
      prescaler_q <= prescaler_q + 9'h001;
    end
  end

  // Interval tap decode; prohibited codes give no interval events
  always @* begin
    tap_hit = 1'b0;
    if (interval_select <= `ISEL_MAX) begin
      tap_hit = ((prescaler_q & tap_mask[interval_select]) == tap_mask[interval_select]);
    end
    interval_evt = operation_enable & watch_count_clock & tap_hit;
  end

  // Watch counter sequencing
  // Arming swallows the first prescaler wrap after enable, so the first
  // watch event comes late; a counter-only restart skips arming, which
  // leaves the first period short by whatever the prescaler already holds.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOPPED: begin
        if (operation_enable && counter_run) begin
          state_d = ST_ARMING;
        end
      end
      ST_ARMING: begin
        if (!operation_enable) begin
          state_d = ST_STOPPED;
        end else if (prescaler_wrap) begin
          state_d = ST_COUNTING;
        end
      end
      ST_COUNTING: begin
        if (!operation_enable) begin
          state_d = ST_STOPPED;
        end
      end
      default: begin
        state_d = ST_STOPPED;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_STOPPED;
    end else begin
      state_q <= state_d;
    end
  end

  // 5-bit counter steps once per prescaler cycle while running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_cnt_q <= 5'h00;
    end else if (!operation_enable || !counter_run) begin
      watch_cnt_q <= 5'h00;
    end else if (state_q == ST_COUNTING && prescaler_wrap) begin
      watch_cnt_q <= watch_cnt_q + 5'h01;
    end
  end

  // Overflow of the 5-bit counter: 32 x 512 watch clocks, half a second at 32.768 kHz
  always @* begin
    watch_evt = operation_enable & counter_run & (state_q == ST_COUNTING) &
                prescaler_wrap & (&watch_cnt_q);
  end

  // Sticky status; a new event beats a write-one clear in the same cycle
  always @* begin
    irq_status_d = irq_status_q;
    if (write_now && hit_status) begin
      irq_status_d = irq_status_q & ~pwdata[`EVT_WIDTH-1:0];
    end
    if (watch_evt) begin
      irq_status_d[`EVT_WATCH_BIT] = 1'b1;
    end
    if (interval_evt) begin
      irq_status_d[`EVT_INTERVAL_BIT] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 2'h0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // Both functions drive the one request line, one cycle behind status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_interrupt_request <= 1'b0;
    end else begin
      watch_interrupt_request <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read mux; unmapped indices answer zero with an error
  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = ~hit_any; // Unmapped index answers with an error
    if (hit_wmc) begin
      rdata_d[7:0] = watch_mode_control_q;
    end else if (hit_status) begin
      rdata_d[`EVT_WIDTH-1:0] = irq_status_q;
    end else if (hit_mask) begin
      rdata_d[`EVT_WIDTH-1:0] = irq_mask_q;
    end else if (hit_state) begin
      rdata_d[8:0]   = prescaler_q;
      rdata_d[20:16] = watch_cnt_q;
      rdata_d[25:24] = state_q;
    end
  end

  // APB answer: registered so every bus output comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_access) begin
      pready  <= 1'b1;
      pslverr <= rerr_d;
      prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule // watch_interval_timer

//--- tb/watch_timer_chk_props.sv
// Checker of bus and timer port rules, bound to the watch timer top
`timescale 1ns/10ps
`include "watch_timer_consts.vh"
module watch_timer_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sub_clock,
  input wire        watch_interrupt_request
);
  // Shadow of the mode register, so reads of the counts can be judged
  reg  [7:0]  mode_q;
  wire        acc  = psel && penable;
  wire        done = acc && pready;
  wire [15:0] idx  = paddr[17:2];
  wire        rdst = done && !pwrite && idx == `COUNT_STATE_IDX;
  wire        mapd = idx >= `WMC_IDX && idx <= `COUNT_STATE_IDX;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_q <= 8'h00;
    else if (done && pwrite && idx == `WMC_IDX)
      mode_q <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_wait; $rose(penable) && psel |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_cause; pready |-> $past(acc); endproperty
  a_cause: assert property (p_cause) else $error("stray pready");
  property p_err; done |-> pslverr == !mapd; endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("prdata not idle");
  property p_mode; done && !pwrite && idx == `WMC_IDX |-> prdata == {24'h00_0000, mode_q & `WMC_WRITE_MASK}; endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  property p_stop; rdst && !mode_q[0] |-> prdata[20:0] == 21'h00_0000; endproperty
  a_stop: assert property (p_stop) else $error("counts not clear");
  property p_run; rdst && !mode_q[1] |-> prdata[20:16] == 5'h00; endproperty
  a_run: assert property (p_run) else $error("counter not clear");
  property p_mask; done && pwrite && idx == `IRQ_MASK_IDX && pwdata[1:0] == 2'h0 |-> ##2 !watch_interrupt_request; endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
endmodule // watch_timer_chk

bind watch_interval_timer watch_timer_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sub_clock(sub_clock),
  .watch_interrupt_request(watch_interrupt_request));

//--- tb/watch_interval_timer_bench.sv
// Self-checking bench for the watch and interval timer
`timescale 1ns/10ps
`include "watch_timer_consts.vh"
module watch_interval_timer_bench;
  reg          pclk = 0;
  reg          presetn = 0;
  reg          psel = 0;
  reg          penable = 0;
  reg          pwrite = 0;
  reg  [17:0]  paddr = 18'h0_0000;
  reg  [31:0]  pwdata = 32'h0000_0000;
  reg          sub_clock = 0;
  wire [31:0]  prdata;
  wire         pready;
  wire         pslverr;
  wire         irq;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic        err;

  watch_interval_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_clock(sub_clock), .watch_interrupt_request(irq));

  // Clock; the subsystem clock toggles each rising edge so a watch tick comes every two cycles
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    sub_clock <= ~sub_clock;
    cyc <= cyc + 1;
  end

  // 33 bits so the error flag rides along with the read data
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
      mismatches++;
    if (seen !== exp)
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
  endtask

  task summarize;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One transfer; request held until pready is seen, read data taken then
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for the interrupt; two cycles first since it lags a status clear
  task wirq(input int lim, output int t);
    int n;
    n = 0;
    repeat (2) @(negedge pclk);
    while (irq !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    t = cyc;
  endtask

  // Clears status before each wait; gap of the last two events is the period
  task period(input int lim, input int k, output int p, output int f);
    int t;
    int tp;
    f = 0;
    repeat (k) begin
      tp = t;
      apb(1'b1, `IRQ_STATUS_IDX, 32'h0000_0003);
      wirq(lim, t);
      if (f == 0)
        f = t;
    end
    p = t - tp;
  endtask

  task t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, `WMC_IDX + i, 32'h0000_0000);
      chk({err, rd}, 33'h0_0000_0000);
    end
    apb(1'b1, `WMC_IDX, 32'h0000_00f3);
    apb(1'b0, `WMC_IDX, 32'h0000_0000);
    chk(rd, 32'h0000_00f3);
    apb(1'b0, 16'hff4e, 32'h0000_0000);
    chk({err, rd}, 33'h1_0000_0000);
  endtask

  task t_stop;
    apb(1'b1, `WMC_IDX, 32'h0000_0081);
    repeat (100) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, `IRQ_STATUS_IDX, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b0, `COUNT_STATE_IDX, 32'h0000_0000);
    chk(rd[20:16], 5'h00);
    // Prohibited codes, then a full stop, must raise nothing
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `WMC_IDX, m == 2 ? 32'h0000_0000 : 32'h0000_00e1 | (m << 4));
      apb(1'b1, `IRQ_STATUS_IDX, 32'h0000_0003);
      repeat (1500) @(posedge pclk);
      apb(1'b0, `IRQ_STATUS_IDX, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b0, `COUNT_STATE_IDX, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask

  task t_interval;
    int p;
    int f;
    apb(1'b1, `IRQ_MASK_IDX, 32'h0000_0002);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `WMC_IDX, 32'h0000_0081 | (c << 4));
      period(2100, 3, p, f);
      chk(p, 2 << (4 + c));
    end
    apb(1'b1, `WMC_IDX, 32'h0000_0001);
    period(4200, 3, p, f);
    chk(p, 2048);
  endtask

  task t_watch;
    int p;
    int f;
    int t0;
    apb(1'b1, `IRQ_MASK_IDX, 32'h0000_0001);
    apb(1'b1, `WMC_IDX, 32'h0000_0083);
    t0 = cyc;
    period(40000, 2, p, f);
    chk(p, 32768);
    chk(f - t0 >= 32768 && f - t0 <= 34000, 1);
    apb(1'b0, `IRQ_STATUS_IDX, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, `WMC_IDX, 32'h0000_0000);
  endtask

  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_stop;
    t_interval;
    t_watch;
    summarize;
  end

  // Watchdog well past the expected run of about 85k cycles
  initial begin
    #3_000_000;
    mismatches++;
    summarize;
  end
endmodule // watch_interval_timer_bench
